// [shared/irq_vec_cfg.svh]
// register offsets, field positions, widths and reset values of the vector block
`ifndef IRQ_VEC_CFG_SVH
`define IRQ_VEC_CFG_SVH

// register indices on the plain register port
`define OFS_PRIORITY_LEVELS_NINE 5'h09
`define OFS_VECTOR_TABLE_BASE    5'h0A
`define OFS_FAST_ZERO_MATCH      5'h0B
`define OFS_FAST_ZERO_ADDR_LOW   5'h0C
`define OFS_FAST_ZERO_ADDR_HIGH  5'h0D
`define OFS_FAST_ONE_MATCH       5'h0E
`define OFS_FAST_ONE_ADDR_LOW    5'h0F
`define OFS_FAST_ONE_ADDR_HIGH   5'h10
`define OFS_EVENT_STATUS         5'h18
`define OFS_EVENT_MASK           5'h19

// low bit of each two-bit request field in the ninth priority register
`define FLD_PWM_B_RELOAD_LO      4'h8
`define FLD_CONV_A_ZERO_LIMIT_LO 4'h6
`define FLD_CONV_B_ZERO_LIMIT_LO 4'h4
`define FLD_CONV_A_DONE_LO       4'h2
`define FLD_CONV_B_DONE_LO       4'h0

// implemented widths
`define BASE_WIDTH       13
`define MATCH_WIDTH      7
`define ADDR_LOW_WIDTH   16
`define ADDR_HIGH_WIDTH  5
`define ADDR_BUS_WIDTH   21
`define EVENT_WIDTH      3

// event status bit positions
`define EVT_FAST_ZERO    2'h0
`define EVT_FAST_ONE     2'h1
`define EVT_FAST_MISCFG  2'h2

// reset values
`define RST_REG16        16'h0000
`define RST_EVENT        3'h0

`endif

// [shared/irq_vec_pkg.sv]
// types shared by the vector configuration block
package irq_vec_pkg;
  // two-bit request priority field encoding
  typedef enum logic [1:0] {
    LVL_OFF = 2'b00,
    LVL_0   = 2'b01,
    LVL_1   = 2'b10,
    LVL_2   = 2'b11
  } request_level_t;

  // kind of vector presented to the core
  typedef enum logic [1:0] {
    KIND_NONE      = 2'b00,
    KIND_NORMAL    = 2'b01,
    KIND_FAST_ZERO = 2'b10,
    KIND_FAST_ONE  = 2'b11
  } vector_kind_t;
endpackage

// [rtl/irq_priority_fast_vector.sv]
// priority fields, vector base and fast vector registers with vector selection
// Overview of operation
// R1: field 00 off, 01/10/11 levels 0..2
// R2: these sources only reach levels 0 to 2
// R3: pwm b reload 9-8, conv a zero 7-6
// R4: conv b zero 5-4, done a 3-2, b 1-0
// R5: base bits 12-0 form address top
// R6: winner's seven-bit number, zero-padded to eight bits, appended below base
// R7: unimplemented upper bits read zero, ignore writes
// R8: fast zero match holds vector number 6-0
// R9: fast one match holds 7-bit vector number
// R10: matched fast request presents programmed fast address
// R11: software sets fast sources to level 2
// R12: fast request beats every other level-2 request
// R13: fast zero served before fast one
// R14: fast zero low register gives bits 15-0
// R15: fast zero high register gives bits 20-16
// R16: fast one low and high form address
// R17: all registers reset to zero
// R18: disabled request never arbitrates nor presents
//
// Design decision made here: strobed register access.
`include "irq_vec_cfg.svh"

module irq_priority_fast_vector #(
  parameter logic [6:0] PWM_B_RELOAD_VECTOR      = 7'h40,  // vector numbers of the
  parameter logic [6:0] CONV_A_ZERO_LIMIT_VECTOR = 7'h41,  // five sources, set at
  parameter logic [6:0] CONV_B_ZERO_LIMIT_VECTOR = 7'h42,  // integration time
  parameter logic [6:0] CONV_A_DONE_VECTOR       = 7'h43,
  parameter logic [6:0] CONV_B_DONE_VECTOR       = 7'h44
) (
  // clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_sys_rst,
  // register port
  input  wire logic [4:0]                        i_addr,
  input  wire logic [15:0]                       i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [15:0]                       o_rdata,
  // request sources, same clock domain, level high while pending
  input  wire logic                              i_pwm_b_reload_req,
  input  wire logic                              i_conv_a_zero_limit_req,
  input  wire logic                              i_conv_b_zero_limit_req,
  input  wire logic                              i_conv_a_done_req,
  input  wire logic                              i_conv_b_done_req,
  // vector to the core
  output logic      [20:0]                       o_vector_address_bus,
  output logic                                   o_vector_valid,
  output irq_vec_pkg::request_level_t            o_vector_level,
  output irq_vec_pkg::vector_kind_t              o_vector_kind,
  // block interrupt
  output logic                                   o_int
);
  import irq_vec_pkg::*;

  localparam int NUM_SRC = 5;  // sources held in the ninth priority register

  // elaboration check: the five vector numbers must be distinct
  // checked while elaborating, so a clash never reaches simulation
  if (PWM_B_RELOAD_VECTOR == CONV_A_ZERO_LIMIT_VECTOR ||
        PWM_B_RELOAD_VECTOR == CONV_B_ZERO_LIMIT_VECTOR ||
        PWM_B_RELOAD_VECTOR == CONV_A_DONE_VECTOR ||
        PWM_B_RELOAD_VECTOR == CONV_B_DONE_VECTOR ||
        CONV_A_ZERO_LIMIT_VECTOR == CONV_B_ZERO_LIMIT_VECTOR ||
        CONV_A_ZERO_LIMIT_VECTOR == CONV_A_DONE_VECTOR ||
        CONV_A_ZERO_LIMIT_VECTOR == CONV_B_DONE_VECTOR ||
        CONV_B_ZERO_LIMIT_VECTOR == CONV_A_DONE_VECTOR ||
        CONV_B_ZERO_LIMIT_VECTOR == CONV_B_DONE_VECTOR ||
        CONV_A_DONE_VECTOR == CONV_B_DONE_VECTOR) begin
    $error("source vector numbers must be distinct");
  end

  // pick a two-bit level field out of the priority register
  function automatic request_level_t field_level(input logic [15:0] reg_val,
                                                 input logic [3:0]  lo);
    logic [15:0] shifted;
    shifted = reg_val >> lo;
    return request_level_t'(shifted[1:0]);  // [R1]
  endfunction

  // software registers
  logic [15:0]                      priority_levels_nine;  // whole word, all fields rw
  logic [`BASE_WIDTH-1:0]           vector_table_base;     // jump table base
  logic [`MATCH_WIDTH-1:0]          fast_zero_match;       // fast zero vector number
  logic [`ADDR_LOW_WIDTH-1:0]       fast_zero_addr_low;    // fast zero address 15-0
  logic [`ADDR_HIGH_WIDTH-1:0]      fast_zero_addr_high;   // fast zero address 20-16
  logic [`MATCH_WIDTH-1:0]          fast_one_match;        // fast one vector number
  logic [`ADDR_LOW_WIDTH-1:0]       fast_one_addr_low;     // fast one address 15-0
  logic [`ADDR_HIGH_WIDTH-1:0]      fast_one_addr_high;    // fast one address 20-16
  logic [`EVENT_WIDTH-1:0]          event_status;          // sticky events
  logic [`EVENT_WIDTH-1:0]          event_mask;            // event enables

  // per-source views
  logic [NUM_SRC-1:0]               src_req;               // request levels
  request_level_t                   src_lvl [NUM_SRC];     // decoded fields
  logic [`MATCH_WIDTH-1:0]          src_vec [NUM_SRC];     // vector numbers

  // arbitration results
  logic                             next_valid;            // some request wins
  request_level_t                   next_level;            // winner's level
  vector_kind_t                     next_kind;             // winner's vector kind
  logic [`ADDR_BUS_WIDTH-1:0]       next_address;          // address for the core
  logic [`EVENT_WIDTH-1:0]          event_hit;             // events this cycle

  // write decode helpers
  logic                             wr_prio;
  logic                             wr_base;
  logic                             wr_fz_match;
  logic                             wr_fz_low;
  logic                             wr_fz_high;
  logic                             wr_fo_match;
  logic                             wr_fo_low;
  logic                             wr_fo_high;
  logic                             wr_status;
  logic                             wr_mask;

  // source table, order fixed by register layout
  always_comb begin
    src_req[0] = i_pwm_b_reload_req;
    src_req[1] = i_conv_a_zero_limit_req;
    src_req[2] = i_conv_b_zero_limit_req;
    src_req[3] = i_conv_a_done_req;
    src_req[4] = i_conv_b_done_req;
    src_lvl[0] = field_level(priority_levels_nine, `FLD_PWM_B_RELOAD_LO);       // [R3]
    src_lvl[1] = field_level(priority_levels_nine, `FLD_CONV_A_ZERO_LIMIT_LO);  // [R3]
    src_lvl[2] = field_level(priority_levels_nine, `FLD_CONV_B_ZERO_LIMIT_LO);  // [R4]
    src_lvl[3] = field_level(priority_levels_nine, `FLD_CONV_A_DONE_LO);        // [R4]
    src_lvl[4] = field_level(priority_levels_nine, `FLD_CONV_B_DONE_LO);        // [R4]
    src_vec[0] = PWM_B_RELOAD_VECTOR;
    src_vec[1] = CONV_A_ZERO_LIMIT_VECTOR;
    src_vec[2] = CONV_B_ZERO_LIMIT_VECTOR;
    src_vec[3] = CONV_A_DONE_VECTOR;
    src_vec[4] = CONV_B_DONE_VECTOR;
  end

  // address decode for writes
  always_comb begin
    wr_prio     = i_wr && (i_addr == `OFS_PRIORITY_LEVELS_NINE);
    wr_base     = i_wr && (i_addr == `OFS_VECTOR_TABLE_BASE);
    wr_fz_match = i_wr && (i_addr == `OFS_FAST_ZERO_MATCH);
    wr_fz_low   = i_wr && (i_addr == `OFS_FAST_ZERO_ADDR_LOW);
    wr_fz_high  = i_wr && (i_addr == `OFS_FAST_ZERO_ADDR_HIGH);
    wr_fo_match = i_wr && (i_addr == `OFS_FAST_ONE_MATCH);
    wr_fo_low   = i_wr && (i_addr == `OFS_FAST_ONE_ADDR_LOW);
    wr_fo_high  = i_wr && (i_addr == `OFS_FAST_ONE_ADDR_HIGH);
    wr_status   = i_wr && (i_addr == `OFS_EVENT_STATUS);
    wr_mask     = i_wr && (i_addr == `OFS_EVENT_MASK);
  end

  // priority register, all fields cleared at reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      priority_levels_nine <= `RST_REG16;  // [R1] [R17]
    end else if (wr_prio) begin
      priority_levels_nine <= i_wdata;
    end
  end

  // vector base, upper bits not stored
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      vector_table_base <= `BASE_WIDTH'(`RST_REG16);  // [R17]
    end else if (wr_base) begin
      vector_table_base <= i_wdata[`BASE_WIDTH-1:0];  // [R5] [R7]
    end
  end

  // fast interrupt zero registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fast_zero_match     <= `MATCH_WIDTH'(`RST_REG16);      // [R17]
      fast_zero_addr_low  <= `RST_REG16;
      fast_zero_addr_high <= `ADDR_HIGH_WIDTH'(`RST_REG16);
    end else begin
      if (wr_fz_match) begin
        fast_zero_match <= i_wdata[`MATCH_WIDTH-1:0];        // [R8] [R7]
      end
      if (wr_fz_low) begin
        fast_zero_addr_low <= i_wdata;                       // [R14]
      end
      if (wr_fz_high) begin
        fast_zero_addr_high <= i_wdata[`ADDR_HIGH_WIDTH-1:0];  // [R15] [R7]
      end
    end
  end

  // fast interrupt one registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fast_one_match     <= `MATCH_WIDTH'(`RST_REG16);       // [R17]
      fast_one_addr_low  <= `RST_REG16;
      fast_one_addr_high <= `ADDR_HIGH_WIDTH'(`RST_REG16);
    end else begin
      if (wr_fo_match) begin
        fast_one_match <= i_wdata[`MATCH_WIDTH-1:0];         // [R9] [R7]
      end
      if (wr_fo_low) begin
        fast_one_addr_low <= i_wdata;                        // [R16]
      end
      if (wr_fo_high) begin
        fast_one_addr_high <= i_wdata[`ADDR_HIGH_WIDTH-1:0];  // [R16] [R7]
      end
    end
  end

  // arbitration: level first, then fast zero, fast one, then lowest vector
  always_comb begin
    logic [3:0]              best_key;
    logic [3:0]              key;
    logic [`MATCH_WIDTH-1:0] best_vec;
    logic                    is_fz;
    logic                    is_fo;
    best_key     = 4'h0;
    key          = 4'h0;
    best_vec     = `MATCH_WIDTH'(`RST_REG16);
    is_fz        = 1'b0;
    is_fo        = 1'b0;
    next_valid   = 1'b0;
    next_level   = LVL_OFF;
    next_kind    = KIND_NONE;
    event_hit    = `RST_EVENT;
    for (int i = 0; i < NUM_SRC; i++) begin
      is_fz = (src_vec[i] == fast_zero_match);
      is_fo = (src_vec[i] == fast_one_match);
      // fast bits only count at level 2, where they lift above other level 2
      key = {src_lvl[i], (src_lvl[i] == LVL_2) && is_fz,
             (src_lvl[i] == LVL_2) && is_fo && !is_fz};  // [R12] [R13] [R2]
      // a requesting fast source at level 0 or 1 is flagged as misconfigured
      if (src_req[i] && (src_lvl[i] != LVL_OFF) && (src_lvl[i] != LVL_2)
          && (is_fz || is_fo)) begin
        event_hit[`EVT_FAST_MISCFG] = 1'b1;  // [R11]
      end
      if (src_req[i] && (src_lvl[i] != LVL_OFF)) begin  // [R18]
        if (!next_valid || (key > best_key) ||
            ((key == best_key) && (src_vec[i] < best_vec))) begin
          next_valid = 1'b1;
          best_key   = key;
          best_vec   = src_vec[i];
          next_level = src_lvl[i];
        end
      end
    end
    if (next_valid) begin
      if (best_key[1]) begin
        next_kind = KIND_FAST_ZERO;  // [R13]
      end else if (best_key[0]) begin
        next_kind = KIND_FAST_ONE;
      end else begin
        next_kind = KIND_NORMAL;
      end
    end
    // form the address for the chosen kind
    unique case (next_kind)
      KIND_FAST_ZERO: next_address = {fast_zero_addr_high, fast_zero_addr_low};  // [R10] [R15]
      KIND_FAST_ONE:  next_address = {fast_one_addr_high, fast_one_addr_low};    // [R16]
      KIND_NORMAL:    next_address = {vector_table_base, 1'b0, best_vec};        // [R5] [R6]
      KIND_NONE:      next_address = `ADDR_BUS_WIDTH'(`RST_REG16);               // [R18]
    endcase
    event_hit[`EVT_FAST_ZERO] = (next_kind == KIND_FAST_ZERO);
    event_hit[`EVT_FAST_ONE]  = (next_kind == KIND_FAST_ONE);
  end

  // vector outputs to the core, registered
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_vector_address_bus <= `ADDR_BUS_WIDTH'(`RST_REG16);
      o_vector_valid       <= 1'b0;
      o_vector_level       <= LVL_OFF;
      o_vector_kind        <= KIND_NONE;
    end else begin
      o_vector_address_bus <= next_address;  // [R10]
      o_vector_valid       <= next_valid;    // [R18]
      o_vector_level       <= next_level;
      o_vector_kind        <= next_kind;
    end
  end

  // sticky event status, write one to clear, a new event wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      event_status <= `RST_EVENT;
    end else if (wr_status) begin
      event_status <= (event_status & ~i_wdata[`EVENT_WIDTH-1:0]) | event_hit;
    end else begin
      event_status <= event_status | event_hit;
    end
  end

  // event mask register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      event_mask <= `RST_EVENT;
    end else if (wr_mask) begin
      event_mask <= i_wdata[`EVENT_WIDTH-1:0];
    end
  end

  // interrupt level from the registered status and mask
  always_comb begin
    o_int = |(event_status & event_mask);
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= `RST_REG16;
    end else if (i_rd) begin
      unique case (i_addr)
        `OFS_PRIORITY_LEVELS_NINE: o_rdata <= priority_levels_nine;
        `OFS_VECTOR_TABLE_BASE:    o_rdata <= 16'(vector_table_base);    // [R7]
        `OFS_FAST_ZERO_MATCH:      o_rdata <= 16'(fast_zero_match);      // [R7]
        `OFS_FAST_ZERO_ADDR_LOW:   o_rdata <= fast_zero_addr_low;
        `OFS_FAST_ZERO_ADDR_HIGH:  o_rdata <= 16'(fast_zero_addr_high);  // [R7]
        `OFS_FAST_ONE_MATCH:       o_rdata <= 16'(fast_one_match);       // [R9]
        `OFS_FAST_ONE_ADDR_LOW:    o_rdata <= fast_one_addr_low;
        `OFS_FAST_ONE_ADDR_HIGH:   o_rdata <= 16'(fast_one_addr_high);   // [R7]
        `OFS_EVENT_STATUS:         o_rdata <= 16'(event_status);
        `OFS_EVENT_MASK:           o_rdata <= 16'(event_mask);
        default:                   o_rdata <= `RST_REG16;  // unmapped reads zero
      endcase
    end else begin
      o_rdata <= `RST_REG16;
    end
  end

endmodule

// [tb/irq_vec_properties.sv]
// concurrent checks on the ports of the vector configuration block
`include "irq_vec_cfg.svh"

module irq_vec_properties (
  // clock and reset
  input wire logic                         i_clk,
  input wire logic                         i_sys_rst,
  // register port
  input wire logic [4:0]                   i_addr,
  input wire logic [15:0]                  i_wdata,
  input wire logic                         i_wr,
  input wire logic                         i_rd,
  input wire logic [15:0]                  o_rdata,
  // request sources
  input wire logic                         i_pwm_b_reload_req,
  input wire logic                         i_conv_a_zero_limit_req,
  input wire logic                         i_conv_b_zero_limit_req,
  input wire logic                         i_conv_a_done_req,
  input wire logic                         i_conv_b_done_req,
  // vector to the core
  input wire logic [20:0]                  o_vector_address_bus,
  input wire logic                         o_vector_valid,
  input wire irq_vec_pkg::request_level_t  o_vector_level,
  input wire irq_vec_pkg::vector_kind_t    o_vector_kind,
  input wire logic                         o_int
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_vec_pkg::*;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // a read strobe aimed at one register index
  sequence rd_of(logic [4:0] a);
    i_rd && i_addr == a;
  endsequence
  // no source is requesting at all
  sequence all_quiet;
    !(i_pwm_b_reload_req || i_conv_a_zero_limit_req || i_conv_b_zero_limit_req ||
      i_conv_a_done_req || i_conv_b_done_req);
  endsequence

  chk_rdata_quiet: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside the read slot");
  chk_base_upper: assert property (rd_of(`OFS_VECTOR_TABLE_BASE) |=>
      o_rdata[15:13] == 3'h0)
    else $error("base register upper bits not zero");
  chk_match0_upper: assert property (rd_of(`OFS_FAST_ZERO_MATCH) |=>
      o_rdata[15:7] == 9'h000)
    else $error("fast zero match upper bits not zero");
  chk_match1_upper: assert property (rd_of(`OFS_FAST_ONE_MATCH) |=>
      o_rdata[15:7] == 9'h000)
    else $error("fast one match upper bits not zero");
  chk_high_upper: assert property (rd_of(`OFS_FAST_ZERO_ADDR_HIGH) |=>
      o_rdata[15:5] == 11'h000)
    else $error("fast address high upper bits not zero");
  chk_level_live: assert property (o_vector_valid |-> o_vector_level != LVL_OFF)
    else $error("valid vector carries a disabled level");
  chk_idle_quiet: assert property (!o_vector_valid |->
      o_vector_kind == KIND_NONE && o_vector_level == LVL_OFF)
    else $error("idle vector carries a kind or level");
  chk_fast_top: assert property (o_vector_kind inside {KIND_FAST_ZERO, KIND_FAST_ONE} |->
      o_vector_level == LVL_2 && o_vector_valid)
    else $error("fast vector below the top level");
  chk_no_request: assert property (all_quiet ##1 all_quiet |-> !o_vector_valid)
    else $error("vector presented with no request");
  chk_normal_pad: assert property (o_vector_kind == KIND_NORMAL |->
      o_vector_address_bus[7] == 1'b0)
    else $error("normal offset not a zero extended number");
  chk_reset_clear: assert property (disable iff (1'b0) i_sys_rst |=>
      !o_vector_valid && o_rdata == 16'h0000 && !o_int)
    else $error("outputs not cleared by reset");
endmodule

// [tb/core_model.sv]
// behavioural core that takes the presented vector when asked
module core_model (
  // clock and reset
  input wire logic                         i_clk,
  input wire logic                         i_sys_rst,
  // take request from the bench
  input wire logic                         i_sample,
  // vector presented by the block
  input wire logic [20:0]                  i_address,
  input wire logic                         i_valid,
  input wire irq_vec_pkg::request_level_t  i_level,
  input wire irq_vec_pkg::vector_kind_t    i_kind,
  // what the core took
  output logic                             o_seen,
  output logic [25:0]                      o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_vec_pkg::*;

  // latch the jump target and flag it on the same edge, one cycle after the take request
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_seen <= 1'b0;
      o_word <= 26'h000_0000;
    end else begin
      o_seen <= i_sample;
      if (i_sample) o_word <= {i_valid, i_level, i_kind, i_address};
    end
  end
endmodule

// [tb/irq_priority_fast_vector_tb.sv]
// self-checking bench for the vector configuration block
module irq_priority_fast_vector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_vec_pkg::*;

  logic           i_clk = 1'b0;           // bench clock
  logic           i_sys_rst = 1'b1;       // reset held at start
  logic [4:0]     i_addr = 5'h00;         // register port
  logic [15:0]    i_wdata = 16'h0000;
  logic           i_wr = 1'b0;
  logic           i_rd = 1'b0;
  logic [4:0]     req = 5'h00;            // pwm, conv a zero, conv b zero, a done, b done
  logic [15:0]    o_rdata;
  logic [20:0]    o_vector_address_bus;
  logic           o_vector_valid;
  logic           o_int;
  request_level_t o_vector_level;
  vector_kind_t   o_vector_kind;
  logic           sample = 1'b0;          // ask the core to take the vector
  logic           seen;
  logic [25:0]    word;
  logic           rd_q = 1'b0;            // read slot marker
  logic           int_q = 1'b0;           // interrupt slot marker
  int             mismatches = 0;
  int             num_checks = 0;
  int             cycles = 0;
  logic [31:0]    expq[$];                // expected results in order
  string          nameq[$];
  logic [15:0]    base, lo0, hi0, lo1, hi1;
  logic [4:0]     offs[10] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10,
                               5'h18, 5'h19};
  logic [15:0]    masks[10] = '{16'hFFFF, 16'h1FFF, 16'h007F, 16'hFFFF, 16'h001F, 16'h007F,
                                16'hFFFF, 16'h001F, 16'h0000, 16'h0007};

  irq_priority_fast_vector irq_priority_fast_vector_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pwm_b_reload_req(req[4]), .i_conv_a_zero_limit_req(req[3]),
    .i_conv_b_zero_limit_req(req[2]), .i_conv_a_done_req(req[1]),
    .i_conv_b_done_req(req[0]), .o_vector_address_bus(o_vector_address_bus),
    .o_vector_valid(o_vector_valid), .o_vector_level(o_vector_level),
    .o_vector_kind(o_vector_kind), .o_int(o_int));
  core_model core_model_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sample(sample), .i_address(o_vector_address_bus),
    .i_valid(o_vector_valid), .i_level(o_vector_level), .i_kind(o_vector_kind),
    .o_seen(seen), .o_word(word));

  // free running clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // compare one value, count and report
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one-cycle register write
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // one-cycle register read, expectation noted first
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    expq.push_back({16'h0000, e});
    nameq.push_back($sformatf("reg %h", a));
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  // set requests, let them settle, have the core take the vector
  task automatic vec(input logic [4:0] r, input logic [25:0] e);
    @(posedge i_clk);
    req <= r;
    expq.push_back({6'h00, e});
    nameq.push_back("vector");
    repeat (3) @(posedge i_clk);
    sample <= 1'b1;
    @(posedge i_clk);
    sample <= 1'b0;
    @(posedge i_clk);
  endtask

  // interrupt level noted now, looked at on the next edge
  task automatic intchk(input logic e);
    expq.push_back({31'h0, e});
    nameq.push_back("int");
    int_q <= 1'b1;
    @(posedge i_clk);
    int_q <= 1'b0;
  endtask

  // watcher: read slot, core take or interrupt slot pops the oldest note
  always @(posedge i_clk) begin
    if (rd_q || seen || int_q) begin
      check(nameq.pop_front(), int_q ? {31'h0, o_int} :
            rd_q ? {16'h0000, o_rdata} : {6'h00, word}, expq.pop_front());
    end
    rd_q <= i_rd;
  end

  // hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h17e2893d));
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (offs[k]) rd(offs[k], 16'h0000);
    foreach (offs[k]) begin
      wr(offs[k], 16'hFFFF);
      rd(offs[k], masks[k]);
    end
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    base = 16'($urandom());
    wr(5'h0A, base);
    wr(5'h0B, 16'h0000);
    wr(5'h0E, 16'h0000);
    wr(5'h19, 16'h0000);
    // each field alone at each code, all sources requesting
    for (int i = 0; i < 5; i++) begin
      for (int c = 0; c < 4; c++) begin
        wr(5'h09, 16'(c << (8 - 2 * i)));
        vec(5'h1F, c == 0 ? 26'h000_0000 :
            {1'b1, 2'(c), KIND_NORMAL, base[12:0], 1'b0, 7'(7'h40 + i)});
      end
    end
    wr(5'h09, 16'h0103);
    vec(5'h1F, {1'b1, 2'h3, KIND_NORMAL, base[12:0], 1'b0, 7'h44});
    // fast vectors at the top level, fast zero match with junk upper bits
    lo0 = 16'($urandom());
    hi0 = 16'($urandom());
    lo1 = 16'($urandom());
    hi1 = 16'($urandom());
    wr(5'h09, 16'h03FF);
    wr(5'h0B, 16'hFFC4);
    wr(5'h0E, 16'h0043);
    wr(5'h0C, lo0);
    wr(5'h0D, hi0);
    wr(5'h0F, lo1);
    wr(5'h10, hi1);
    wr(5'h19, 16'h0007);
    vec(5'h1F, {1'b1, 2'h3, KIND_FAST_ZERO, hi0[4:0], lo0});
    intchk(1'b1);
    vec(5'h1E, {1'b1, 2'h3, KIND_FAST_ONE, hi1[4:0], lo1});
    vec(5'h1C, {1'b1, 2'h3, KIND_NORMAL, base[12:0], 1'b0, 7'h40});
    wr(5'h18, 16'h0007);
    intchk(1'b0);
    wr(5'h19, 16'h0000);
    vec(5'h1F, {1'b1, 2'h3, KIND_FAST_ZERO, hi0[4:0], lo0});
    intchk(1'b0);
    rd(5'h18, 16'h0001);
    // disabled fast source, then a fast source at a low level
    wr(5'h09, 16'h03FC);
    vec(5'h01, 26'h000_0000);
    wr(5'h09, 16'h0001);
    wr(5'h18, 16'h0007);
    wr(5'h19, 16'h0004);
    vec(5'h01, {1'b1, 2'h1, KIND_NORMAL, base[12:0], 1'b0, 7'h44});
    intchk(1'b1);
    // second reset in mid-run clears everything
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(5'h0A, 16'h0000);
    vec(5'h1F, 26'h000_0000);
    conclude();
  end
endmodule

bind irq_priority_fast_vector irq_vec_properties irq_vec_properties_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_b_reload_req(i_pwm_b_reload_req),
  .i_conv_a_zero_limit_req(i_conv_a_zero_limit_req),
  .i_conv_b_zero_limit_req(i_conv_b_zero_limit_req), .i_conv_a_done_req(i_conv_a_done_req),
  .i_conv_b_done_req(i_conv_b_done_req), .o_vector_address_bus(o_vector_address_bus),
  .o_vector_valid(o_vector_valid), .o_vector_level(o_vector_level),
  .o_vector_kind(o_vector_kind), .o_int(o_int));
